/* tb/ots_relay_model.sv */
// far side: relay coils and controller inputs that read the terminals
module ots_relay_model #(
   parameter int N = 7
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [N-1:0] term,
   output logic      [N-1:0] contact
);
   timeunit 1ns;
   timeprecision 1ns;
   // contacts pick up one clock after the terminal changes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         contact <= '0;
      end else begin
         contact <= term;
      end
   end
endmodule

/* tb/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ots_pkg::*;
   localparam int CODES[17] = '{0, 1, 2, 3, 4, 5, 7, 8, 10, 11, 14, 15, 16, 17, 18, 19, 25};
   localparam int BAD[7]    = '{6, 9, 26, 99, 117, 119, 200};
   logic              sys_clk;
   logic              nrst;
   logic [6:0]        addr;
   logic              rd;
   logic              wr;
   logic [31:0]       wdata;
   logic [3:0]        be;
   logic [31:0]       rdata;
   logic              waitreq;
   ots_drive_status_t ds;
   logic [15:0]       ofreq, sfreq, cur, pwr, duty, acc;
   logic [6:0]        term, seen, exp;
   logic [31:0]       rng, q, v;
   int                miscompares, n_checks, cfg[11], sel_m[7], c, t;
   int                rej_q[$];

   ots_main #(.TICK_CYCLES(4)) dut_u (
      .SYS_CLK(sys_clk), .NRST(nrst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(waitreq), .DRIVE_STATUS(ds), .OUT_FREQ(ofreq), .SET_FREQ(sfreq),
      .OUT_CURRENT(cur), .OUT_POWER(pwr), .BRAKE_DUTY(duty), .THERMAL_ACC(acc),
      .TERM_OUT(term));
   ots_relay_model partner_u (.clk(sys_clk), .nrst(nrst), .term(term), .contact(seen));

   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // reference model of each condition except the timed ones, codes 12 and 13
   function automatic logic cond_of(int k);
      int f;
      int s;
      f = int'(ofreq);
      s = int'(sfreq);
      case (k)
         0: return ds.running && f >= cfg[0];
         1: return ds.running && (f >= s ? f - s : s - f) <= cfg[10];
         2: return ds.supply_loss_flag | ds.undervoltage;
         3: return ds.overload_flag;
         4: return f >= (ds.reverse ? cfg[2] : cfg[1]);
         5: return f >= cfg[3];
         7: return int'(duty) * 100 >= cfg[8] * 85;
         8: return int'(acc) * 100 >= cfg[9] * 85;
         10: return ds.panel_op_mode_flag;
         11: return ds.reset_done & (ds.start_possible | ds.running);
         14: return ds.pid_low_limit_flag;
         15: return ds.pid_high_limit_flag;
         16: return ds.pid_forward_flag;
         17: return ds.bypass_contactor_a;
         18: return ds.bypass_contactor_b;
         19: return ds.bypass_contactor_c;
         25: return ds.fan_alarm;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic term_of(int s);
      if (s == 9999) return 1'b0;
      if (s >= 100) return !cond_of(s - 100);
      return cond_of(s);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
      n_checks++;
      if (got !== want) begin
         miscompares++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, want);
      end
   endtask

   task automatic bus(input logic w, input int a, input int d, output logic [31:0] r);
      int n;
      @(posedge sys_clk);
      addr <= 7'(a);
      wdata <= 32'(d);
      wr <= w;
      rd <= !w;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      if (n >= 20) chk(0, 1, "bus answer timeout");
      r = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      wait_n(60000);
      chk(0, 1, "watchdog expired");
      print_verdict();
   end

   initial begin
      {nrst, rd, wr, addr, wdata, ds, ofreq, sfreq, cur, pwr, duty, acc} = '0;
      be = 4'hf;
      rng = 32'h0000_0060;
      wait_n(5);
      chk(term, 0, "terminals in reset");
      nrst <= 1'b1;
      sel_m = '{0, 1, 2, 3, 4, 9999, 9999};
      cfg = '{default: 0};
      for (int i = 0; i < 7; i++) begin
         bus(0, 4 * i, 0, q);
         chk(q, sel_m[i], "reset selection");
      end
      for (int i = 0; i < 11; i++) begin
         bus(0, 32 + 4 * i, 0, q);
         chk(q, 0, "reset config");
      end
      $display("test reset values done");
      for (int r = 0; r < 150; r++) begin
         c = CODES[rnd() % 17];
         if (rnd() % 2 == 1 && (c < 17 || c > 19)) c += 100;
         t = r % 7;
         bus(1, 4 * t, c, q);
         sel_m[t] = c;
         c = rnd() % 11;
         cfg[c] = rnd() % 16;
         bus(1, 32 + 4 * c, cfg[c], q);
         @(posedge sys_clk);
         v = rnd();
         ds <= v[14:0];
         ofreq <= 16'(rnd() % 16);
         sfreq <= 16'(rnd() % 16);
         duty <= 16'(rnd() % 16);
         acc <= 16'(rnd() % 16);
         cur <= 16'(rnd() % 16);
         pwr <= 16'(rnd() % 16);
         wait_n(5);
         for (int i = 0; i < 7; i++) exp[i] = term_of(sel_m[i]);
         chk(term, exp, "terminal vector");
         chk(seen, exp, "relay contacts");
         bus(0, 76, 0, q);
         for (int k = 0; k < 17; k++) chk(q[CODES[k]], cond_of(CODES[k]), "condition bit");
      end
      $display("test random routing done");
      for (int k = 0; k < 7; k++) begin
         t = 2 * (k % 2);
         rej_q.push_back(BAD[k]);
         bus(1, 4 * t, BAD[k], q);
         bus(0, 4 * t, 0, q);
         chk(q, sel_m[t], "rejected code kept old");
         bus(0, 80, 0, q);
         chk(q[8], 1, "reject flag set");
         bus(0, 84, 0, q);
         chk(q, rej_q.pop_front(), "rejected code");
         bus(1, 80, 32'h0000_0100, q);
         bus(0, 80, 0, q);
         chk(q[8], 0, "reject flag cleared");
      end
      bus(1, 88, 5, q);
      bus(0, 88, 0, q);
      chk(q, 0, "unmapped address");
      $display("test rejection done");
      cur <= 16'h0000;
      pwr <= 16'h0009;
      bus(1, 48, 5, q);
      bus(1, 52, 2, q);
      bus(1, 56, 5, q);
      bus(1, 60, 2, q);
      bus(1, 0, 12, q);
      bus(1, 4, 113, q);
      wait_n(40);
      chk(term[1:0], 2'h2, "timed idle");
      cur <= 16'h0009;
      wait_n(6);
      chk(term[0], 0, "current not yet long");
      wait_n(40);
      chk(term[0], 1, "current held long");
      pwr <= 16'h0001;
      wait_n(6);
      chk(term[1], 1, "power not yet long");
      wait_n(40);
      chk(term[1], 0, "power held low");
      cur <= 16'h0000;
      wait_n(6);
      chk(term[0], 0, "current dropped");
      $display("test timed detection done");
      print_verdict();
   end
endmodule

/* verilog/ots_main.sv */
// Implementation choices: the register offsets and register access over Avalon-MM.
`include "ots_regs.svh"

module ots_main
   import ots_pkg::*;
#(
   parameter int NTERM       = 7,
   parameter int DW          = 16,
   parameter bit LARGE_MODEL = 1'b1,
   parameter int TICK_CYCLES = `OTS_TICK_NS / `OTS_CLK_NS
) (
   input  wire logic              SYS_CLK,
   input  wire logic              NRST,
   input  wire logic [6:0]        AVS_ADDRESS,
   input  wire logic              AVS_READ,
   input  wire logic              AVS_WRITE,
   input  wire logic [31:0]       AVS_WRITEDATA,
   input  wire logic [3:0]        AVS_BYTEENABLE,
   output logic      [31:0]       AVS_READDATA,
   output logic                   AVS_WAITREQUEST,
   input  wire ots_drive_status_t DRIVE_STATUS,
   input  wire logic [DW-1:0]     OUT_FREQ,
   input  wire logic [DW-1:0]     SET_FREQ,
   input  wire logic [DW-1:0]     OUT_CURRENT,
   input  wire logic [DW-1:0]     OUT_POWER,
   input  wire logic [DW-1:0]     BRAKE_DUTY,
   input  wire logic [DW-1:0]     THERMAL_ACC,
   output logic      [NTERM-1:0]  TERM_OUT
);

   // ****************************************************************
   // bus slave: one wait state per access
   // ****************************************************************
   logic            ack;
   logic            wr_go;
   logic            is_sel;
   logic            is_cfg;
   logic [4:0]      word;
   logic [3:0]      cfg_idx;
   logic [DW-1:0]   cfg [`OTS_CFG_COUNT];
   ots_code_t       sel [NTERM];
   ots_code_t       wr_code [NTERM];
   logic            reject;
   ots_code_t       rej_code;
   ots_cond_t       cond_q;
   ots_cond_t       next_cond;
   logic [31:0]     next_rdata;

   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
   assign wr_go           = AVS_WRITE && ack;
   assign word            = AVS_ADDRESS[6:2];
   assign is_sel          = (word < 5'(NTERM));
   assign is_cfg          = (AVS_ADDRESS >= `OTS_CFG_BASE)
                         && (AVS_ADDRESS < `OTS_COND_STAT);
   assign cfg_idx         = 4'(5'(AVS_ADDRESS[6:2] - `OTS_CFG_BASE / 4));

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         ack <= 1'b0;
      end else begin
         ack <= AVS_WAITREQUEST;
      end
   end

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   function automatic logic code_ok(input ots_code_t c);
      logic       neg;
      logic [4:0] b;
      logic       base;
      neg  = (c >= `OTS_NEG_OFS);
      b    = neg ? 5'(c - `OTS_NEG_OFS) : c[4:0];
      base = (b <= `OTS_C_FDET2) || b == `OTS_C_THERM
          || (b >= `OTS_C_PANEL && b <= `OTS_C_BYP_C) || b == `OTS_C_FAN
          || (b == `OTS_C_BRAKE && LARGE_MODEL);
      if (c == `OTS_CODE_NONE) begin
         code_ok = 1'b1;
      end else if (c >= `OTS_CODE_LIMIT || (neg ? c[15:0] - `OTS_NEG_OFS > `OTS_C_FAN
                                                : c > `OTS_C_FAN)) begin
         code_ok = 1'b0;
      end else if (neg && b >= `OTS_C_BYP_A && b <= `OTS_C_BYP_C) begin
         code_ok = 1'b0;
      end else begin
         code_ok = base;
      end
   endfunction

   // ****************************************************************
   // terminal selections and mappers
   // ****************************************************************
   genvar t;
   generate
      for (t = 0; t < NTERM; t++) begin : g_term
         assign wr_code[t] = merge16(sel[t], AVS_WRITEDATA, AVS_BYTEENABLE);

         always_ff @(posedge SYS_CLK or negedge NRST) begin
            if (!NRST) begin
               sel[t] <= (t < `OTS_FIRST_RELAY) ? 16'(t) : `OTS_CODE_NONE;
            end else if (wr_go && is_sel && word == 5'(t) && code_ok(wr_code[t])) begin
               sel[t] <= wr_code[t];
            end
         end

         ots_term_map u_map (
            .clk  (SYS_CLK),
            .nrst (NRST),
            .code (sel[t]),
            .cond (cond_q),
            .term (TERM_OUT[t])
         );
      end
   endgenerate

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         reject   <= 1'b0;
         rej_code <= '0;
      end else if (wr_go && is_sel && !code_ok(wr_code[word[2:0]])) begin
         reject   <= 1'b1;
         rej_code <= wr_code[word[2:0]];
      end else if (wr_go && AVS_ADDRESS == `OTS_TERM_STAT
                   && AVS_BYTEENABLE[1] && AVS_WRITEDATA[`OTS_REJ_BIT]) begin
         reject <= 1'b0;
      end
   end

   // ****************************************************************
   // configuration words
   // ****************************************************************
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         for (int i = 0; i < `OTS_CFG_COUNT; i++) begin
            cfg[i] <= '0;
         end
      end else if (wr_go && is_cfg) begin
         cfg[cfg_idx] <= DW'(merge16(16'(cfg[cfg_idx]), AVS_WRITEDATA, AVS_BYTEENABLE));
      end
   end

   // ****************************************************************
   // read data
   // ****************************************************************
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (is_sel) begin
         next_rdata[15:0] = sel[word[2:0]];
      end else if (is_cfg) begin
         next_rdata[DW-1:0] = cfg[cfg_idx];
      end else if (AVS_ADDRESS == `OTS_COND_STAT) begin
         next_rdata[OTS_NCOND-1:0] = cond_q;
      end else if (AVS_ADDRESS == `OTS_TERM_STAT) begin
         next_rdata[NTERM-1:0]     = TERM_OUT;
         next_rdata[`OTS_REJ_BIT]  = reject;
      end else if (AVS_ADDRESS == `OTS_REJ_CODE) begin
         next_rdata[15:0] = rej_code;
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (AVS_READ && !ack) begin
         AVS_READDATA <= next_rdata;
      end
   end

   // ****************************************************************
   // millisecond tick for detection timers
   // ****************************************************************
   logic [31:0] tick_cnt;
   logic        tick;

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         tick_cnt <= 32'h0000_0000;
         tick     <= 1'b0;
      end else begin
         tick     <= (tick_cnt == 32'(TICK_CYCLES - 1));
         tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tick_cnt + 1'b1;
      end
   end

   // ****************************************************************
   // condition detectors
   // ****************************************************************
   logic          over_hit;
   logic          zero_hit;
   logic [DW-1:0] freq_diff;
   logic          run_ok;
   logic          brake_pre;
   logic          therm_pre;

   ots_persist #(.W(DW)) u_overcur (
      .clk   (SYS_CLK),
      .nrst  (NRST),
      .tick  (tick),
      .cond  (OUT_CURRENT > cfg[`OTS_CFG_CUR_LVL]),
      .limit (cfg[`OTS_CFG_CUR_TIME]),
      .hit   (over_hit)
   );

   ots_persist #(.W(DW)) u_zerocur (
      .clk   (SYS_CLK),
      .nrst  (NRST),
      .tick  (tick),
      .cond  (OUT_POWER < cfg[`OTS_CFG_ZERO_LVL]),
      .limit (cfg[`OTS_CFG_ZERO_TIME]),
      .hit   (zero_hit)
   );

   assign freq_diff = (OUT_FREQ >= SET_FREQ) ? OUT_FREQ - SET_FREQ : SET_FREQ - OUT_FREQ;
   assign run_ok    = DRIVE_STATUS.running && OUT_FREQ >= cfg[`OTS_CFG_START_FREQ];
   assign brake_pre = LARGE_MODEL && (32'(BRAKE_DUTY) * `OTS_FULL_PCT
                   >= 32'(cfg[`OTS_CFG_BRAKE_DUTY]) * `OTS_PRE_PCT);
   assign therm_pre = (32'(THERMAL_ACC) * `OTS_FULL_PCT
                   >= 32'(cfg[`OTS_CFG_THERM_TRIP]) * `OTS_PRE_PCT);

   always_comb begin
      next_cond = '0;
      next_cond[`OTS_C_RUN]      = run_ok;
      next_cond[`OTS_C_SPEED]    = DRIVE_STATUS.running && freq_diff <= cfg[`OTS_CFG_SPEED_BAND];
      next_cond[`OTS_C_SUPPLY]   = DRIVE_STATUS.supply_loss_flag || DRIVE_STATUS.undervoltage;
      next_cond[`OTS_C_OVERLOAD] = DRIVE_STATUS.overload_flag;
      next_cond[`OTS_C_FDET]     = DRIVE_STATUS.reverse ? OUT_FREQ >= cfg[`OTS_CFG_FDET_REV]
                                                        : OUT_FREQ >= cfg[`OTS_CFG_FDET_FWD];
      next_cond[`OTS_C_FDET2]    = OUT_FREQ >= cfg[`OTS_CFG_FDET2];
      next_cond[`OTS_C_BRAKE]    = brake_pre;
      next_cond[`OTS_C_THERM]    = therm_pre;
      next_cond[`OTS_C_PANEL]    = DRIVE_STATUS.panel_op_mode_flag;
      next_cond[`OTS_C_READY]    = DRIVE_STATUS.reset_done
                                && (DRIVE_STATUS.start_possible || DRIVE_STATUS.running);
      next_cond[`OTS_C_OVERCUR]  = over_hit;
      next_cond[`OTS_C_ZEROCUR]  = zero_hit;
      next_cond[`OTS_C_PID_LOW]  = DRIVE_STATUS.pid_low_limit_flag;
      next_cond[`OTS_C_PID_HIGH] = DRIVE_STATUS.pid_high_limit_flag;
      next_cond[`OTS_C_PID_FWD]  = DRIVE_STATUS.pid_forward_flag;
      next_cond[`OTS_C_BYP_A]    = DRIVE_STATUS.bypass_contactor_a;
      next_cond[`OTS_C_BYP_B]    = DRIVE_STATUS.bypass_contactor_b;
      next_cond[`OTS_C_BYP_C]    = DRIVE_STATUS.bypass_contactor_c;
      next_cond[`OTS_C_FAN]      = DRIVE_STATUS.fan_alarm;
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         cond_q <= '0;
      end else begin
         cond_q <= next_cond;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   a_bus_one_wait: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ((AVS_READ || AVS_WRITE) && !ack) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
      else $error("bus access not answered after one wait state");

   a_run_thresh: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      cond_q[`OTS_C_RUN] |-> $past(DRIVE_STATUS.running)
                          && $past(OUT_FREQ) >= $past(cfg[`OTS_CFG_START_FREQ]))
      else $error("run condition without start frequency reached");

   a_rev_thresh: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (DRIVE_STATUS.reverse && OUT_FREQ < cfg[`OTS_CFG_FDET_REV]) |=> !cond_q[`OTS_C_FDET])
      else $error("reverse frequency detect ignored its threshold");

   a_ready_reset: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      !DRIVE_STATUS.reset_done |=> !cond_q[`OTS_C_READY])
      else $error("ready before reset processing completed");

   a_supply_loss: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      DRIVE_STATUS.undervoltage |=> cond_q[`OTS_C_SUPPLY])
      else $error("undervoltage not reported");

   a_brake_pre: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      cond_q[`OTS_C_BRAKE] |-> $past(32'(BRAKE_DUTY)) * `OTS_FULL_PCT
                             >= $past(32'(cfg[`OTS_CFG_BRAKE_DUTY])) * `OTS_PRE_PCT)
      else $error("brake pre-alarm below 85 percent");

   a_bypass_pos: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (wr_go && is_sel && wr_code[word[2:0]] >= `OTS_NEG_OFS + `OTS_C_BYP_A
                       && wr_code[word[2:0]] <= `OTS_NEG_OFS + `OTS_C_BYP_C)
      |=> reject && $stable(sel[0]))
      else $error("inverted bypass code accepted");

   a_reject_keep: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (wr_go && word == 5'h00 && !code_ok(wr_code[0])) |=> $stable(sel[0]) && reject)
      else $error("rejected code changed the selection");

   a_stall_hold: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      DRIVE_STATUS.overload_flag [*2] |-> cond_q[`OTS_C_OVERLOAD])
      else $error("overload alarm dropped while stall active");

   a_fan_alarm: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      DRIVE_STATUS.fan_alarm |=> cond_q[`OTS_C_FAN])
      else $error("fan alarm not reported");

   a_reject_code: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (wr_go && is_sel && !code_ok(wr_code[word[2:0]]))
      |=> rej_code == $past(wr_code[word[2:0]]))
      else $error("rejected code not recorded");

endmodule

/* verilog/ots_persist.sv */
// level detector that fires once its input has held longer than a limit
module ots_persist #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         tick,
   input  wire logic         cond,
   input  wire logic [W-1:0] limit,
   output logic              hit
);

   logic [W-1:0] cnt;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= '0;
      end else if (!cond) begin
         cnt <= '0;
      end else if (tick && cnt != '1) begin
         cnt <= cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hit <= 1'b0;
      end else begin
         hit <= cond && (cnt > limit);
      end
   end

   a_persist_drop: assert property (@(posedge clk) disable iff (!nrst)
      !cond |=> !hit)
      else $error("detector output while input inactive");

endmodule

/* verilog/ots_pkg.sv */
package ots_pkg;

   localparam int OTS_NCOND = 26;

   typedef logic [15:0]           ots_code_t;
   typedef logic [OTS_NCOND-1:0]  ots_cond_t;

   typedef struct packed {
      logic running;
      logic reverse;
      logic supply_loss_flag;
      logic undervoltage;
      logic overload_flag;
      logic panel_op_mode_flag;
      logic reset_done;
      logic start_possible;
      logic pid_low_limit_flag;
      logic pid_high_limit_flag;
      logic pid_forward_flag;
      logic bypass_contactor_a;
      logic bypass_contactor_b;
      logic bypass_contactor_c;
      logic fan_alarm;
   } ots_drive_status_t;

endpackage

/* verilog/ots_regs.svh */
`ifndef OTS_REGS_SVH
`define OTS_REGS_SVH

// ****************************************************************
// register map, byte addresses
// ****************************************************************
`define OTS_SEL_BASE        7'h00
`define OTS_CFG_BASE        7'h20
`define OTS_COND_STAT       7'h4c
`define OTS_TERM_STAT       7'h50
`define OTS_REJ_CODE        7'h54
`define OTS_CFG_COUNT       11

// config word indices from OTS_CFG_BASE
`define OTS_CFG_START_FREQ  4'd0
`define OTS_CFG_FDET_FWD    4'd1
`define OTS_CFG_FDET_REV    4'd2
`define OTS_CFG_FDET2       4'd3
`define OTS_CFG_CUR_LVL     4'd4
`define OTS_CFG_CUR_TIME    4'd5
`define OTS_CFG_ZERO_LVL    4'd6
`define OTS_CFG_ZERO_TIME   4'd7
`define OTS_CFG_BRAKE_DUTY  4'd8
`define OTS_CFG_THERM_TRIP  4'd9
`define OTS_CFG_SPEED_BAND  4'd10

// ****************************************************************
// fields and codes
// ****************************************************************
`define OTS_REJ_BIT         8
`define OTS_CODE_NONE       16'h270f
`define OTS_NEG_OFS         16'h0064
`define OTS_CODE_LIMIT      16'h00c8
`define OTS_FIRST_RELAY     5
`define OTS_PRE_PCT         32'h0000_0055
`define OTS_FULL_PCT        32'h0000_0064

// condition indices, equal to the positive-logic code
`define OTS_C_RUN           5'h00
`define OTS_C_SPEED         5'h01
`define OTS_C_SUPPLY        5'h02
`define OTS_C_OVERLOAD      5'h03
`define OTS_C_FDET          5'h04
`define OTS_C_FDET2         5'h05
`define OTS_C_BRAKE         5'h07
`define OTS_C_THERM         5'h08
`define OTS_C_PANEL         5'h0a
`define OTS_C_READY         5'h0b
`define OTS_C_OVERCUR       5'h0c
`define OTS_C_ZEROCUR       5'h0d
`define OTS_C_PID_LOW       5'h0e
`define OTS_C_PID_HIGH      5'h0f
`define OTS_C_PID_FWD       5'h10
`define OTS_C_BYP_A         5'h11
`define OTS_C_BYP_B         5'h12
`define OTS_C_BYP_C         5'h13
`define OTS_C_FAN           5'h19

// ****************************************************************
// timing
// ****************************************************************
`define OTS_CLK_NS          10
`define OTS_TICK_NS         1000000

`endif

/* verilog/ots_term_map.sv */
`include "ots_regs.svh"

// one terminal: pick a condition by code and apply its polarity
module ots_term_map
   import ots_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      nrst,
   input  wire ots_code_t code,
   input  wire ots_cond_t cond,
   output logic           term
);

   logic       neg;
   logic [4:0] idx;
   logic       next_term;

   always_comb begin
      neg = (code >= `OTS_NEG_OFS);
      idx = neg ? 5'(code - `OTS_NEG_OFS) : code[4:0];
      if (code == `OTS_CODE_NONE) begin
         next_term = 1'b0;
      end else begin
         next_term = cond[idx] ^ neg;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         term <= 1'b0;
      end else begin
         term <= next_term;
      end
   end

   a_term_polarity: assert property (@(posedge clk) disable iff (!nrst)
      (code != `OTS_CODE_NONE && code >= `OTS_NEG_OFS) ##1 $stable(code)
      |-> term == !$past(cond[idx]))
      else $error("negative logic terminal not inverted");

endmodule
